//--- edge_capture_checker.sv
`timescale 1ns/1ps

module edge_capture_checker #(
	parameter int HADDR_W = 8
) (
	input wire logic               clk_i,
	input wire logic               sys_rst_i,
	input wire logic               hsel_i,
	input wire logic [HADDR_W-1:0] haddr_i,
	input wire logic [1:0]         htrans_i,
	input wire logic               hwrite_i,
	input wire logic [31:0]        hwdata_i,
	input wire logic               hready_i,
	input wire logic               capture_tick_o,
	input wire logic               interval_tick_o,
	input wire logic               ms_tick_o,
	input wire logic               irq0_o,
	input wire logic               irq1_o
);
	edge_capture_pkg::clock_config_t cfg_r;
	logic        cfg_wr_r;
	logic        wr_r;
	logic        ms_seen_r;
	logic [7:0]  age_r;
	logic [15:0] cgap_r;
	logic [15:0] igap_r;
	logic [12:0] ms_cnt_r;
	int          cp;
	int          ip;

	default clocking @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);

	function automatic int per(input logic [1:0] s);
		return (s == 2'h0) ? 1 : (s == 2'h1) ? 2 : 4;
	endfunction : per

	// Shadow of clock setup, age since its last write, gaps between ticks
	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
		begin
			cfg_r     <= edge_capture_pkg::CLK_CFG_RST;
			cfg_wr_r  <= 1'b0;
			wr_r      <= 1'b0;
			age_r     <= 8'h00;
			cgap_r    <= 16'h0000;
			igap_r    <= 16'h0000;
			ms_cnt_r  <= 13'h0000;
			ms_seen_r <= 1'b0;
		end
		else
		begin
			wr_r     <= hsel_i & htrans_i[1] & hready_i & hwrite_i;
			cfg_wr_r <= hsel_i & htrans_i[1] & hready_i & hwrite_i
				& (haddr_i[7:2] == edge_capture_pkg::IDX_CLK_CFG);
			if (cfg_wr_r)
				cfg_r <= hwdata_i[7:0];
			age_r     <= cfg_wr_r ? 8'h00 : age_r + {7'h00, age_r != 8'hFF};
			cgap_r    <= capture_tick_o ? 16'h0001 : cgap_r + 16'h0001;
			igap_r    <= interval_tick_o ? 16'h0001 : igap_r + 16'h0001;
			ms_cnt_r  <= ms_tick_o ? 13'h0000 : ms_cnt_r + {12'h000, capture_tick_o};
			ms_seen_r <= ms_seen_r | ms_tick_o;
		end
	end

	always_comb
	begin
		cp = 2 * (cfg_r.cap_div + 1) * per(cfg_r.cap_sel);
		ip = (cfg_r.int_div + 1)
			* ((cfg_r.int_sel == edge_capture_pkg::SRC_ALT) ? cp : per(cfg_r.int_sel));
	end

	a_cap_period: assert property (capture_tick_o && age_r > cgap_r + 16'd40 |-> cgap_r == cp)
		else $error("capture tick period wrong");
	a_int_period: assert property (interval_tick_o && age_r > igap_r + 16'd40 |-> igap_r == ip)
		else $error("interval tick period wrong");
	a_stop_freeze: assert property (age_r > 8'd4 && cfg_r.cap_sel == edge_capture_pkg::SRC_ALT |-> !capture_tick_o)
		else $error("capture tick while stopped");
	a_tick_single: assert property (capture_tick_o |=> !capture_tick_o)
		else $error("capture tick wider than one cycle");
	a_irq0_cause: assert property ($rose(irq0_o) |-> $past(capture_tick_o, 2))
		else $error("irq0 rose without capture");
	a_irq1_cause: assert property ($rose(irq1_o) |-> $past(capture_tick_o, 2))
		else $error("irq1 rose without capture");
	a_irq_hold: assert property ($fell(irq0_o) || $fell(irq1_o) |-> $past(wr_r) || $past(wr_r, 2))
		else $error("irq dropped without write");
	a_ms_count: assert property (ms_tick_o && ms_seen_r |-> ms_cnt_r + capture_tick_o == 4096)
		else $error("ms tick spacing wrong");
endmodule : edge_capture_checker

bind edge_capture_timer edge_capture_checker #(.HADDR_W(HADDR_W)) i_chk (
	.clk_i, .sys_rst_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hwdata_i, .hready_i,
	.capture_tick_o, .interval_tick_o, .ms_tick_o, .irq0_o, .irq1_o
);

//--- edge_capture_pkg.sv
package edge_capture_pkg;

	// Register indices; byte address is four times the index
	localparam logic [5:0] IDX_IN0_RISE  = 6'h22;
	localparam logic [5:0] IDX_IN1_RISE  = 6'h23;
	localparam logic [5:0] IDX_IN0_FALL  = 6'h24;
	localparam logic [5:0] IDX_IN1_FALL  = 6'h25;
	localparam logic [5:0] IDX_CAP_CFG   = 6'h2A;
	localparam logic [5:0] IDX_IRQ_EN    = 6'h2B;
	localparam logic [5:0] IDX_IRQ_STAT  = 6'h2C;
	localparam logic [5:0] IDX_CLK_CFG   = 6'h31;

	// Reset values
	localparam logic [7:0] CAPTURE_RST   = 8'h00;
	localparam logic [7:0] CAP_CFG_RST   = 8'h00;
	localparam logic [3:0] IRQ_EN_RST    = 4'h0;
	localparam logic [3:0] IRQ_STAT_RST  = 4'h0;
	localparam logic [7:0] CLK_CFG_RST   = 8'h8F;
	localparam logic [15:0] FRC_RST      = 16'h0000;

	// Divider step: capture divides by 2*(code+1), interval by code+1
	localparam int CAP_DIV_STEP = 2;
	localparam int INT_DIV_STEP = 1;

	// Millisecond tick assumes this capture clock rate
	localparam int MS_TICK_US     = 1024;
	localparam int CAP_REF_MHZ    = 4;
	localparam int MS_TICK_CYCLES = MS_TICK_US * CAP_REF_MHZ;
	localparam int CAP_MAX_MHZ    = 12;

	// AHB-Lite encodings
	localparam logic       HRESP_OKAY = 1'b0;
	localparam logic [7:0] UNMAPPED_RD = 8'h00;

	// Clock source codes
	typedef enum logic [1:0] {
		SRC_OSC24 = 2'h0,
		SRC_EXT   = 2'h1,
		SRC_LP32K = 2'h2,
		SRC_ALT   = 2'h3
	} src_sel_t;

	// Capture configuration, bit 7 down to bit 0
	typedef struct packed {
		logic       hold_first;
		logic [2:0] prescale;
		logic       wide;
		logic [2:0] spare;
	} capture_config_t;

	// Timer clock configuration, bit 7 down to bit 0
	typedef struct packed {
		logic [1:0] cap_div;
		src_sel_t   cap_sel;
		logic [1:0] int_div;
		src_sel_t   int_sel;
	} clock_config_t;

	// Latched AHB address phase
	typedef struct packed {
		logic       write;
		logic [5:0] idx;
		logic       aligned;
	} bus_req_t;

endpackage : edge_capture_pkg

//--- edge_capture_timer.sv
// Design decision made here: the AHB-Lite register port.
`timescale 1ns/1ps

// Contract
// - Capture divider codes 00..11 divide source by 2, 4, 6, 8.
// - Capture source: 24 MHz, external, 32 kHz, or stopped for 11.
// - Interval divider codes 00..11 divide source by 1, 2, 3, 4.
// - Interval source: 24 MHz, external, 32 kHz, or capture clock.
// - Hold-first clear: every edge overwrites, latest edge wins.
// - Hold-first set: keep first edge until that register is read.
// - Prescale n captures counter bits n+7 down to n.
// - Wide mode disables input 1; its registers extend input 0.
// - Wide mode: input 0 falling register takes counter low byte.
// - Wide mode: input 1 registers take counter high byte on edge.
// - Rising registers hold prescaled counter at latest rising edge.
// - Falling registers hold prescaled counter at latest falling edge.
// - Enable bits 3..0: in1 fall, in1 rise, in0 fall, in0 rise.
// - Edge sets status bit unless hold-first is holding its register; write one clears, zero leaves it.
// - Capture register updates on third capture tick after edge.
// - Capture clock at most 12 MHz; fast inputs may lose edges.
// - Millisecond tick assumes 4 MHz capture clock, scales with it.
// - Inputs synchronised on capture clock, which also drives counter.
// - One interrupt line per input, shared by both edges.
module edge_capture_timer #(
	parameter int HADDR_W = 8
) (
	input  wire logic               clk_i,
	input  wire logic               sys_rst_i,
	input  wire logic               hsel_i,
	input  wire logic [HADDR_W-1:0] haddr_i,
	input  wire logic [1:0]         htrans_i,
	input  wire logic               hwrite_i,
	input  wire logic [2:0]         hsize_i,
	input  wire logic [31:0]        hwdata_i,
	input  wire logic               hready_i,
	output logic                    hreadyout_o,
	output logic                    hresp_o,
	output logic [31:0]             hrdata_o,
	input  wire logic [1:0]         capture_input_i,
	input  wire logic               osc24_tick_i,
	input  wire logic               external_clock_input_i,
	input  wire logic               lp32k_tick_i,
	output logic                    capture_tick_o,
	output logic                    interval_tick_o,
	output logic                    ms_tick_o,
	output logic                    irq0_o,
	output logic                    irq1_o
);

	typedef enum logic [2:0] {
		BUS_IDLE   = 3'b001,
		BUS_WRITE  = 3'b010,
		BUS_RDWAIT = 3'b100
	} bus_state_t;

	localparam logic [5:0] CAP_IDX [4] = '{
		edge_capture_pkg::IDX_IN0_RISE,
		edge_capture_pkg::IDX_IN0_FALL,
		edge_capture_pkg::IDX_IN1_RISE,
		edge_capture_pkg::IDX_IN1_FALL
	};
	localparam int MS_W = $clog2(edge_capture_pkg::MS_TICK_CYCLES);
	localparam logic [MS_W-1:0] MS_LAST = MS_W'(edge_capture_pkg::MS_TICK_CYCLES - 1);

	edge_capture_pkg::capture_config_t cap_cfg_r;
	edge_capture_pkg::clock_config_t   clk_cfg_r;
	edge_capture_pkg::bus_req_t        req_r;
	bus_state_t                        bus_st_r;
	bus_state_t                        bus_st_nxt;
	logic [3:0]                        irq_en_r;
	logic [3:0]                        stat_r;
	logic [7:0]                        cap_r [4];
	logic [3:0]                        lock_r;
	logic [15:0]                       frc_r;
	logic [1:0]                        sync1_r;
	logic [1:0]                        sync2_r;
	logic [1:0]                        prev_r;
	logic                              ext_prev_r;
	logic [MS_W-1:0]                   ms_cnt_r;
	logic                              ms_tick_r;
	logic [1:0]                        irq_r;
	logic [31:0]                       hrdata_r;
	logic                              ext_tick;
	logic                              cap_src;
	logic                              cap_tick;
	logic                              int_src;
	logic                              int_tick;
	logic                              accept;
	logic                              wr_en;
	logic [7:0]                        wdata;
	logic [1:0]                        rise;
	logic [1:0]                        fall;
	logic [3:0]                        ev;
	logic [3:0]                        take;
	logic [3:0]                        stat_set;
	logic [7:0]                        window;
	logic [7:0]                        rd_data;

	// Clock sources
	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
			ext_prev_r <= 1'b0;
		else
			ext_prev_r <= external_clock_input_i;
	end

	assign ext_tick = external_clock_input_i & ~ext_prev_r;

	always_comb
	begin
		unique case (clk_cfg_r.cap_sel)
			edge_capture_pkg::SRC_OSC24: cap_src = osc24_tick_i;
			edge_capture_pkg::SRC_EXT:   cap_src = ext_tick;
			edge_capture_pkg::SRC_LP32K: cap_src = lp32k_tick_i;
			edge_capture_pkg::SRC_ALT:   cap_src = 1'b0;
		endcase
	end

	always_comb
	begin
		unique case (clk_cfg_r.int_sel)
			edge_capture_pkg::SRC_OSC24: int_src = osc24_tick_i;
			edge_capture_pkg::SRC_EXT:   int_src = ext_tick;
			edge_capture_pkg::SRC_LP32K: int_src = lp32k_tick_i;
			edge_capture_pkg::SRC_ALT:   int_src = cap_tick;
		endcase
	end

	// Capture clock divider
	tick_divider #(
		.STEP  (edge_capture_pkg::CAP_DIV_STEP),
		.CNT_W (3)
	) u_cap_div (
		.clk_i      (clk_i),
		.sys_rst_i  (sys_rst_i),
		.src_tick_i (cap_src),
		.div_code_i (clk_cfg_r.cap_div),
		.tick_o     (cap_tick)
	);

	// Interval clock divider
	tick_divider #(
		.STEP  (edge_capture_pkg::INT_DIV_STEP),
		.CNT_W (2)
	) u_int_div (
		.clk_i      (clk_i),
		.sys_rst_i  (sys_rst_i),
		.src_tick_i (int_src),
		.div_code_i (clk_cfg_r.int_div),
		.tick_o     (int_tick)
	);

	assign capture_tick_o  = cap_tick;
	assign interval_tick_o = int_tick;

	// Millisecond tick counted in capture ticks
	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
		begin
			ms_cnt_r  <= '0;
			ms_tick_r <= 1'b0;
		end
		else
		begin
			ms_tick_r <= cap_tick & (ms_cnt_r == MS_LAST);
			if (cap_tick)
				ms_cnt_r <= (ms_cnt_r == MS_LAST) ? '0 : ms_cnt_r + 1'b1;
		end
	end

	assign ms_tick_o = ms_tick_r;

	// Free-running counter
	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
			frc_r <= edge_capture_pkg::FRC_RST;
		else if (cap_tick)
			frc_r <= frc_r + 16'h0001;
	end

	// Input synchroniser and edge history
	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
		begin
			sync1_r <= 2'h0;
			sync2_r <= 2'h0;
			prev_r  <= 2'h0;
		end
		else if (cap_tick)
		begin
			sync1_r <= capture_input_i;
			sync2_r <= sync1_r;
			prev_r  <= sync2_r;
		end
	end

	// Edge seen on the third capture tick after the pin moves
	assign rise = {2{cap_tick}} & sync2_r & ~prev_r;
	assign fall = {2{cap_tick}} & ~sync2_r & prev_r;

	// Register events; wide mode steers input 0 edges to input 1 slots
	assign ev[0] = rise[0];
	assign ev[1] = fall[0];
	assign ev[2] = cap_cfg_r.wide ? rise[0] : rise[1];
	assign ev[3] = cap_cfg_r.wide ? fall[0] : fall[1];

	// Prescaled byte window
	assign window = frc_r[cap_cfg_r.prescale +: 8];

	assign stat_set = take & {~cap_cfg_r.wide, ~cap_cfg_r.wide, 2'b11};

	// Bus address phase
	assign accept = hsel_i & htrans_i[1] & hready_i;
	assign wr_en  = (bus_st_r == BUS_WRITE) & req_r.aligned;
	assign wdata  = hwdata_i[7:0];

	always_comb
	begin
		bus_st_nxt = BUS_IDLE;
		if (bus_st_r != BUS_RDWAIT && accept)
			bus_st_nxt = hwrite_i ? BUS_WRITE : BUS_RDWAIT;
	end

	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
		begin
			bus_st_r <= BUS_IDLE;
			req_r    <= '0;
		end
		else
		begin
			bus_st_r <= bus_st_nxt;
			if (bus_st_r != BUS_RDWAIT && accept)
			begin
				req_r.write   <= hwrite_i;
				req_r.idx     <= haddr_i[7:2];
				req_r.aligned <= (haddr_i[1:0] == 2'b00) & (hsize_i == 3'b010);
			end
		end
	end

	// Capture registers, one per edge slot
	generate
		for (genvar k = 0; k < 4; k++)
		begin : g_cap
			logic hit;
			logic rel;

			assign hit     = req_r.aligned & (req_r.idx == CAP_IDX[k]);
			assign rel     = (bus_st_r == BUS_RDWAIT) & hit;
			assign take[k] = ev[k] & ~(cap_cfg_r.hold_first & lock_r[k]);

			always_ff @(posedge clk_i)
			begin
				if (sys_rst_i)
				begin
					cap_r[k]  <= edge_capture_pkg::CAPTURE_RST;
					lock_r[k] <= 1'b0;
				end
				else if (take[k])
				begin
					if (cap_cfg_r.wide)
						cap_r[k] <= (k < 2) ? frc_r[7:0] : frc_r[15:8];
					else
						cap_r[k] <= window;
					lock_r[k] <= cap_cfg_r.hold_first;
				end
				else
				begin
					if (wr_en && hit)
						cap_r[k] <= wdata;
					if (rel)
						lock_r[k] <= 1'b0;
				end
			end
		end
	endgenerate

	// Status, set wins over write-one clear
	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
			stat_r <= edge_capture_pkg::IRQ_STAT_RST;
		else if (wr_en && req_r.idx == edge_capture_pkg::IDX_IRQ_STAT)
			stat_r <= (stat_r & ~wdata[3:0]) | stat_set;
		else
			stat_r <= stat_r | stat_set;
	end

	// Configuration registers
	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
		begin
			cap_cfg_r <= edge_capture_pkg::CAP_CFG_RST;
			irq_en_r  <= edge_capture_pkg::IRQ_EN_RST;
			clk_cfg_r <= edge_capture_pkg::CLK_CFG_RST;
		end
		else if (wr_en)
		begin
			if (req_r.idx == edge_capture_pkg::IDX_CAP_CFG)
				cap_cfg_r <= wdata;
			if (req_r.idx == edge_capture_pkg::IDX_IRQ_EN)
				irq_en_r <= wdata[3:0];
			if (req_r.idx == edge_capture_pkg::IDX_CLK_CFG)
				clk_cfg_r <= wdata;
		end
	end

	// Interrupt lines, one per input
	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
			irq_r <= 2'b00;
		else
		begin
			irq_r[0] <= |(stat_r[1:0] & irq_en_r[1:0]);
			irq_r[1] <= |(stat_r[3:2] & irq_en_r[3:2]);
		end
	end

	assign irq0_o = irq_r[0];
	assign irq1_o = irq_r[1];

	// Read mux
	always_comb
	begin
		rd_data = edge_capture_pkg::UNMAPPED_RD;
		if (req_r.aligned)
		begin
			unique case (req_r.idx)
				edge_capture_pkg::IDX_IN0_RISE: rd_data = cap_r[0];
				edge_capture_pkg::IDX_IN0_FALL: rd_data = cap_r[1];
				edge_capture_pkg::IDX_IN1_RISE: rd_data = cap_r[2];
				edge_capture_pkg::IDX_IN1_FALL: rd_data = cap_r[3];
				edge_capture_pkg::IDX_CAP_CFG:  rd_data = cap_cfg_r;
				edge_capture_pkg::IDX_IRQ_EN:   rd_data = {4'h0, irq_en_r};
				edge_capture_pkg::IDX_IRQ_STAT: rd_data = {4'h0, stat_r};
				edge_capture_pkg::IDX_CLK_CFG:  rd_data = clk_cfg_r;
				default:                        rd_data = edge_capture_pkg::UNMAPPED_RD;
			endcase
		end
	end

	// Read data loaded in the wait cycle
	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
			hrdata_r <= 32'h00000000;
		else if (bus_st_r == BUS_RDWAIT)
			hrdata_r <= {24'h000000, rd_data};
	end

	assign hrdata_o    = hrdata_r;
	assign hreadyout_o = (bus_st_r != BUS_RDWAIT);
	assign hresp_o     = edge_capture_pkg::HRESP_OKAY;

endmodule : edge_capture_timer

//--- edge_capture_timer_tb.sv
`timescale 1ns/1ps

module edge_capture_timer_tb;
	typedef struct packed {
		logic [5:0] idx;
		logic       wr;
		logic [7:0] wd;
		logic [7:0] ex;
	} row_t;

	logic        clk_i = 1'b0;
	logic        sys_rst_i = 1'b1;
	logic [7:0]  haddr_i = 8'h00;
	logic [1:0]  htrans_i = 2'h0;
	logic        hwrite_i = 1'b0;
	logic [31:0] hwdata_i = 32'h0;
	logic        ext_r = 1'b0;
	logic        lp_r = 1'b0;
	logic [1:0]  want = 2'h0;
	logic        hreadyout_o, hresp_o, capture_tick_o, interval_tick_o, ms_tick_o, irq0_o, irq1_o;
	logic [31:0] hrdata_o, q;
	logic [1:0]  pins;
	logic [15:0] stamp, s, s1, off;
	int          cyc, miscompares, checked;
	logic [1:0]  pat [4] = '{2'h1, 2'h0, 2'h2, 2'h0};
	logic [5:0]  dst [4] = '{6'h22, 6'h24, 6'h23, 6'h25};
	row_t        rows [16] = '{'{6'h22, 1'b0, 8'h00, 8'h00}, '{6'h23, 1'b0, 8'h00, 8'h00},
		'{6'h24, 1'b0, 8'h00, 8'h00}, '{6'h25, 1'b0, 8'h00, 8'h00}, '{6'h2A, 1'b0, 8'h00, 8'h00},
		'{6'h2B, 1'b0, 8'h00, 8'h00}, '{6'h2C, 1'b0, 8'h00, 8'h00}, '{6'h31, 1'b0, 8'h00, 8'h8F},
		'{6'h10, 1'b0, 8'h00, 8'h00}, '{6'h10, 1'b1, 8'hFF, 8'h00}, '{6'h2A, 1'b1, 8'hA5, 8'hA5},
		'{6'h2B, 1'b1, 8'hFF, 8'h0F}, '{6'h2C, 1'b1, 8'h0F, 8'h00}, '{6'h22, 1'b1, 8'h5A, 8'h5A},
		'{6'h2A, 1'b1, 8'h00, 8'h00}, '{6'h31, 1'b1, 8'h00, 8'h00}};

	edge_capture_timer i_dut (
		.clk_i, .sys_rst_i, .hsel_i(1'b1), .haddr_i, .htrans_i, .hwrite_i, .hsize_i(3'h2),
		.hwdata_i, .hready_i(hreadyout_o), .hreadyout_o, .hresp_o, .hrdata_o,
		.capture_input_i(pins), .osc24_tick_i(1'b1), .external_clock_input_i(ext_r),
		.lp32k_tick_i(lp_r), .capture_tick_o, .interval_tick_o, .ms_tick_o, .irq0_o, .irq1_o
	);

	pin_source i_pins (
		.clk_i, .sys_rst_i, .tick_i(capture_tick_o), .want_i(want), .pins_o(pins), .stamp_o(stamp)
	);

	initial
	begin
		forever #20 clk_i = ~clk_i;
	end

	// Source ticks: external clock period 2, low-power tick every 4; hang guard
	always @(posedge clk_i)
	begin
		cyc++;
		ext_r <= cyc[0];
		lp_r <= (cyc[1:0] == 2'h0);
		if (cyc == 40000)
		begin
			miscompares++;
			conclude();
		end
	end

	task automatic conclude;
		$display("Checks %0d, mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : conclude

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] ex);
		checked++;
		if (seen !== ex)
		begin
			miscompares++;
			$display("BAD %s exp %h seen %h", nm, ex, seen);
		end
	endtask : chk

	task automatic bus(input logic [5:0] idx, input logic wr, input logic [7:0] d);
		htrans_i <= 2'h2;
		haddr_i <= {idx, 2'h0};
		hwrite_i <= wr;
		@(posedge clk_i);
		while (hreadyout_o !== 1'b1)
			@(posedge clk_i);
		htrans_i <= 2'h0;
		hwdata_i <= {24'h0, d};
		@(posedge clk_i);
		while (hreadyout_o !== 1'b1)
			@(posedge clk_i);
		q = hrdata_o;
	endtask : bus

	task automatic rd(input logic [5:0] idx, input logic [7:0] ex);
		bus(idx, 1'b0, 8'h00);
		chk($sformatf("reg %h", idx), q, {24'h0, ex});
	endtask : rd

	task automatic pin(input logic [1:0] v);
		want <= v;
		repeat (24) @(posedge clk_i);
		s = stamp;
	endtask : pin

	initial
	begin
		repeat (3) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		foreach (rows[i])
		begin
			if (rows[i].wr)
				bus(rows[i].idx, 1'b1, rows[i].wd);
			rd(rows[i].idx, rows[i].ex);
			chk("hresp", {31'h0, hresp_o}, 32'h0);
		end
		for (int i = 0; i < 16; i++)
		begin
			bus(6'h31, 1'b1, {i[1:0], i[3:2], i[1:0], i[3:2]});
			repeat (300) @(posedge clk_i);
		end
		bus(6'h31, 1'b1, 8'h00);
		// Wide mode: in1 pin ignored, in1 registers extend in0
		bus(6'h2A, 1'b1, 8'h08);
		pin(2'h1);
		s1 = s;
		pin(2'h3);
		pin(2'h2);
		// Capture lands on the third tick after the pin move
		off = 16'h0003;
		rd(6'h22, 8'(s1 + off));
		rd(6'h23, 8'((s1 + off) >> 8));
		rd(6'h24, 8'(s + off));
		rd(6'h25, 8'((s + off) >> 8));
		rd(6'h2C, 8'h03);
		chk("irq", {30'h0, irq1_o, irq0_o}, 32'h1);
		pin(2'h0);
		bus(6'h2C, 1'b1, 8'h0F);
		for (int n = 0; n < 8; n++)
		begin
			bus(6'h2A, 1'b1, {1'b0, n[2:0], 4'h0});
			for (int k = 0; k < 4; k++)
			begin
				pin(pat[k]);
				rd(dst[k], 8'((s + off) >> n));
			end
			rd(6'h2C, 8'h0F);
			chk("irq", {30'h0, irq1_o, irq0_o}, 32'h3);
			bus(6'h2C, 1'b1, 8'h05);
			rd(6'h2C, 8'h0A);
			bus(6'h2C, 1'b1, 8'h0A);
			rd(6'h2C, 8'h00);
			chk("irq", {30'h0, irq1_o, irq0_o}, 32'h0);
		end
		// Masked rise sets status only
		bus(6'h2B, 1'b1, 8'h0E);
		pin(2'h1);
		rd(6'h2C, 8'h01);
		chk("irq0", {31'h0, irq0_o}, 32'h0);
		bus(6'h2C, 1'b1, 8'h01);
		pin(2'h0);
		chk("irq0", {31'h0, irq0_o}, 32'h1);
		bus(6'h2C, 1'b1, 8'h0F);
		bus(6'h2B, 1'b1, 8'h0F);
		// First edge held until read, then latest edge wins
		bus(6'h2A, 1'b1, 8'h80);
		bus(6'h22, 1'b0, 8'h00);
		pin(2'h1);
		s1 = s;
		pin(2'h0);
		pin(2'h1);
		rd(6'h22, 8'(s1 + off));
		pin(2'h0);
		pin(2'h1);
		rd(6'h22, 8'(s + off));
		bus(6'h2A, 1'b1, 8'h00);
		pin(2'h0);
		pin(2'h1);
		pin(2'h0);
		pin(2'h1);
		rd(6'h22, 8'(s + off));
		pin(2'h0);
		bus(6'h2C, 1'b1, 8'h0F);
		sys_rst_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		rd(6'h31, 8'h8F);
		rd(6'h22, 8'h00);
		bus(6'h31, 1'b1, 8'h00);
		repeat (18000) @(posedge clk_i);
		conclude();
	end
endmodule : edge_capture_timer_tb

//--- pin_source.sv
`timescale 1ns/1ps

module pin_source (
	input  wire logic        clk_i,
	input  wire logic        sys_rst_i,
	input  wire logic        tick_i,
	input  wire logic [1:0]  want_i,
	output logic      [1:0]  pins_o,
	output logic      [15:0] stamp_o
);
	logic [15:0] ticks_r;

	// Pins move only on a capture tick; stamp holds the tick count of the last move
	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
		begin
			ticks_r <= 16'h0000;
			pins_o  <= 2'h0;
			stamp_o <= 16'h0000;
		end
		else if (tick_i)
		begin
			ticks_r <= ticks_r + 16'h0001;
			pins_o  <= want_i;
			if (pins_o != want_i)
				stamp_o <= ticks_r;
		end
	end
endmodule : pin_source

//--- tick_divider.sv
`timescale 1ns/1ps

module tick_divider #(
	parameter int STEP  = 1,
	parameter int CNT_W = 3
) (
	input  wire logic       clk_i,
	input  wire logic       sys_rst_i,
	input  wire logic       src_tick_i,
	input  wire logic [1:0] div_code_i,
	output logic            tick_o
);

	logic [CNT_W-1:0] cnt_r;
	logic [CNT_W-1:0] limit;
	logic             tick_r;

	// Last count of one output period
	assign limit = CNT_W'((STEP * (int'(div_code_i) + 1)) - 1);

	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
		begin
			cnt_r  <= '0;
			tick_r <= 1'b0;
		end
		else if (src_tick_i)
		begin
			if (cnt_r >= limit)
			begin
				cnt_r  <= '0;
				tick_r <= 1'b1;
			end
			else
			begin
				cnt_r  <= cnt_r + 1'b1;
				tick_r <= 1'b0;
			end
		end
		else
		begin
			tick_r <= 1'b0;
		end
	end

	assign tick_o = tick_r;

endmodule : tick_divider
